// ==== rtl/i2c_slave_access.sv ====
// two-wire slave that gives an external host byte access to registers
// Contract
// - scl high: sda falling is start, sda rising is stop.
// - repeated start decodes the next command like stop then start.
// - bytes are eight bits, msb first, sampled while scl high.
// - transmitter changes sda only while scl is low.
// - ninth clock: transmitter releases, receiver pulls low to acknowledge.
// - master nack on read: stop driving, release sda.
// - first byte is address plus direction; ack on match, else ignore.
// - default slave address chosen from the strap level.
// - write: two register address bytes, msb first, both acknowledged.
// - write data go to consecutive registers stepped by direction field.
// - start or stop after address bytes: no write, pointer kept.
// - read: data shifted out right after control byte ack, from pointer.
// - read after multi-byte transfer starts at the advanced pointer.
// - single byte accesses, ascending byte order on the link.
// - bits 15:14 step: 00 increment, 10 decrement, 11 fixed, 01 reserved.
// - step field latched only with a new register address.
// - general call honoured only when its low bit is one, as write.
// - general call with low bit zero: ack first byte, nack the rest.
// - before init done and next start, ignore the bus, refuse bytes.
// - start in low power wakes; scl held low until clocks locked.
// - multi-byte read continues until master nack and stop.
// - pointer wraps to zero past its maximum.
// - unexpected start or stop aborts, ready for next command.
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_access
    import i2c_slave_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             ce,
    input  wire logic             link_clk,
    input  wire logic             serial_clock_pin_in,
    output logic                  serial_clock_pin_out,
    output logic                  serial_clock_pin_oe,
    input  wire logic             serial_data_pin_in,
    output logic                  serial_data_pin_out,
    output logic                  serial_data_pin_oe,
    input  wire logic             addr_select_strap,
    input  wire logic             init_done,
    input  wire logic             low_power,
    input  wire logic             clocks_locked,
    output logic                  wake_req,
    output logic      [PTR_W-1:0] reg_addr,
    output logic      [7:0]       reg_wdata,
    output logic                  reg_wr,
    output logic                  reg_rd,
    input  wire logic [7:0]       reg_rdata
);
    link_state_t s;
    link_state_t n;
    core_state_t c;
    core_state_t nc;
    logic [8:0]  sy;
    logic        req_s;
    logic        scl;
    logic        sda;
    logic        lp;
    logic        lock;
    logic        init;
    logic        strap;
    logic        ce_l;
    logic        ack_s;
    logic        rst_l;
    logic        start_evt;
    logic        stop_evt;
    logic        scl_rise;
    logic        scl_fall;
    logic        fall_go;
    logic        waiting;
    logic        addr_load;

    function automatic logic [PTR_W-1:0] step(
        input logic [PTR_W-1:0] p,
        input logic [1:0]       d
    );
        logic [PTR_W-1:0] r;
        r = p;
        case (d)
            DIR_INC: r = p + PTR_ONE;
            DIR_DEC: r = p - PTR_ONE;
            default: r = p;
        endcase
        return r;
    endfunction : step

    // every pin, strap and cross-domain control level enters the link domain here; c.rdata is read unsynchronised once the answer toggle is seen
    level_sync #(.W(9)) u_link_sync (
        .clk (link_clk),
        .d   ({reset, c.ack_tgl, ce, addr_select_strap, init_done,
                clocks_locked, low_power, serial_data_pin_in,
                serial_clock_pin_in}),
        .q   (sy)
    );

    level_sync #(.W(1)) u_core_sync (
        .clk (clk),
        .d   (s.req_tgl),
        .q   (req_s)
    );

    assign scl   = sy[0];
    assign sda   = sy[1];
    assign lp    = sy[2];
    assign lock  = sy[3];
    assign init  = sy[4];
    assign strap = sy[5];
    assign ce_l  = sy[6];
    assign ack_s = sy[7];
    assign rst_l = sy[8];

    // edges only from the synchronised copies
    assign start_evt = scl && s.prev_scl && s.prev_sda && !sda;
    assign stop_evt  = scl && s.prev_scl && !s.prev_sda && sda;
    assign scl_rise  = scl && !s.prev_scl;
    assign scl_fall  = !scl && s.prev_scl;
    assign fall_go   = scl_fall || s.hold;
    assign waiting   = s.req_tgl != ack_s;

    always_comb begin
        n = s;
        addr_load = 1'b0;
        n.prev_scl = scl;
        n.prev_sda = sda;
        if (!s.strap_taken) begin
            n.strap_taken = 1'b1;
            n.my_addr = strap ? SLAVE_ADDR_STRAP_HI : SLAVE_ADDR_STRAP_LO;
        end
        if (s.waking && lock) begin
            n.waking   = 1'b0;
            n.wake_req = 1'b0;
        end
        if (start_evt || stop_evt) begin
            // last step of a multi-byte write lands on the end condition
            if (s.st == ST_WDATA && s.nbytes == 2'h2) begin
                n.ptr = step(s.ptr, s.dir);
            end
            n.bitcnt = '0;
            n.ackph  = 1'b0;
            n.mack   = 1'b0;
            n.hold   = 1'b0;
            n.sda_oe = 1'b0;
            n.st     = ST_IDLE;
            if (start_evt && (s.ready || init)) begin
                n.ready = 1'b1;
                n.st    = ST_CTRL;
                if (lp) begin
                    n.waking   = 1'b1;
                    n.wake_req = 1'b1;
                end
            end
        end else if (s.st != ST_IDLE && s.st != ST_IGNORE) begin
            if (scl_rise && s.mack) begin
                if (sda) begin
                    n.st   = ST_IGNORE;
                    n.mack = 1'b0;
                    if (s.nbytes != 2'h0) begin
                        n.ptr = step(s.ptr, s.dir);
                    end
                end else begin
                    // prefetch so the next byte is ready at the falling edge
                    n.ptr       = step(s.ptr, s.dir);
                    n.nbytes    = 2'h1;
                    n.req.write = 1'b0;
                    n.req.addr  = step(s.ptr, s.dir);
                    n.req.data  = '0;
                    n.req_tgl   = !s.req_tgl;
                end
            end else if (scl_rise && !s.ackph && s.bitcnt < ACK_BIT) begin
                n.shreg  = {s.shreg[6:0], sda};
                n.bitcnt = s.bitcnt + 4'h1;
            end else if (fall_go) begin
                n.hold = 1'b0;
                if (s.ackph || s.mack) begin
                    if (s.st == ST_RDATA) begin
                        // stretch the clock if the fetch is still in flight
                        if (waiting) begin
                            n.hold = 1'b1;
                        end else begin
                            n.shreg  = c.rdata;
                            n.sda_oe = !c.rdata[7];
                            n.ackph  = 1'b0;
                            n.mack   = 1'b0;
                            n.bitcnt = '0;
                        end
                    end else begin
                        n.sda_oe = 1'b0;
                        n.ackph  = 1'b0;
                        n.bitcnt = '0;
                    end
                end else if (s.bitcnt == ACK_BIT) begin
                    case (s.st)
                        ST_CTRL: begin
                            if (s.shreg[7:1] == GENERAL_CALL && !s.shreg[0]) begin
                                n.sda_oe = 1'b1;
                                n.ackph  = 1'b1;
                                n.st     = ST_GC2;
                            end else if (s.shreg[7:1] == s.my_addr) begin
                                if (s.shreg[0] && waiting) begin
                                    n.hold = 1'b1;
                                end else begin
                                    n.sda_oe = 1'b1;
                                    n.ackph  = 1'b1;
                                    n.nbytes = 2'h0;
                                    if (s.shreg[0]) begin
                                        n.st        = ST_RDATA;
                                        n.req.write = 1'b0;
                                        n.req.addr  = s.ptr;
                                        n.req.data  = '0;
                                        n.req_tgl   = !s.req_tgl;
                                    end else begin
                                        n.st = ST_ADDR_HI;
                                    end
                                end
                            end else begin
                                n.st = ST_IGNORE;
                            end
                        end
                        ST_GC2: begin
                            if (s.shreg[0]) begin
                                n.sda_oe = 1'b1;
                                n.ackph  = 1'b1;
                                n.st     = ST_ADDR_HI;
                            end else begin
                                n.st = ST_IGNORE;
                            end
                        end
                        ST_ADDR_HI: begin
                            n.addr_hi = s.shreg;
                            n.sda_oe  = 1'b1;
                            n.ackph   = 1'b1;
                            n.st      = ST_ADDR_LO;
                        end
                        ST_ADDR_LO: begin
                            // the two high bits above the pointer width become the step field
                            n.ptr     = {s.addr_hi[PTR_HI_BITS-1:0], s.shreg};
                            n.dir     = s.addr_hi[DIR_MSB:DIR_LSB];
                            addr_load = 1'b1;
                            n.nbytes  = 2'h0;
                            n.sda_oe  = 1'b1;
                            n.ackph   = 1'b1;
                            n.st      = ST_WDATA;
                        end
                        ST_WDATA: begin
                            if (waiting) begin
                                n.hold = 1'b1;
                            end else begin
                                // first byte at the pointer, later ones one step on
                                if (s.nbytes == 2'h0) begin
                                    n.req.addr = s.ptr;
                                    n.nbytes   = 2'h1;
                                end else begin
                                    n.req.addr = step(s.ptr, s.dir);
                                    n.ptr      = step(s.ptr, s.dir);
                                    n.nbytes   = 2'h2;
                                end
                                n.req.write = 1'b1;
                                n.req.data  = s.shreg;
                                n.req_tgl   = !s.req_tgl;
                                n.sda_oe    = 1'b1;
                                n.ackph     = 1'b1;
                            end
                        end
                        ST_RDATA: begin
                            n.sda_oe = 1'b0;
                            n.mack   = 1'b1;
                        end
                        default: begin
                            n.st = ST_IGNORE;
                        end
                    endcase
                end else if (s.st == ST_RDATA) begin
                    n.sda_oe = !s.shreg[7];
                end
            end
        end
        n.scl_oe = n.hold || n.waking;
        if (!ce_l) begin
            n = s;
        end
        if (rst_l) begin
            n = '0;
        end
    end

    always_ff @(posedge link_clk) begin
        s <= n;
    end

    // register side: one access per toggle, answered by a toggle back
    always_comb begin
        nc = c;
        nc.reg_wr = 1'b0;
        nc.reg_rd = 1'b0;
        if (c.rd_pend) begin
            nc.rdata   = reg_rdata;
            nc.rd_pend = 1'b0;
            nc.ack_tgl = !c.ack_tgl;
        end else if (req_s != c.req_seen) begin
            // request fields are held steady until the answer toggles
            nc.req_seen = req_s;
            nc.reg_addr = s.req.addr;
            if (s.req.write) begin
                nc.reg_wdata = s.req.data;
                nc.reg_wr    = 1'b1;
                nc.ack_tgl   = !c.ack_tgl;
            end else begin
                nc.reg_rd  = 1'b1;
                nc.rd_pend = 1'b1;
            end
        end
        if (!ce) begin
            nc = c;
        end
        if (reset) begin
            nc = '0;
        end
    end

    always_ff @(posedge clk) begin
        c <= nc;
    end

    assign serial_clock_pin_out = s.scl_o;
    assign serial_clock_pin_oe  = s.scl_oe;
    assign serial_data_pin_out  = s.sda_o;
    assign serial_data_pin_oe   = s.sda_oe;
    assign wake_req             = s.wake_req;
    assign reg_addr             = c.reg_addr;
    assign reg_wdata            = c.reg_wdata;
    assign reg_wr               = c.reg_wr;
    assign reg_rd               = c.reg_rd;

    sequence read_nack_s;
        s.st == ST_RDATA && s.mack && scl_rise && sda && !start_evt && !stop_evt && ce_l;
    endsequence

    sequence released_s;
        s.st == ST_IGNORE && !s.sda_oe;
    endsequence

    chk_read_nack_release: assert property (
        @(posedge link_clk) disable iff (rst_l)
        read_nack_s |=> released_s
    ) else $error("data line still driven after master nack");

    chk_sda_change_low: assert property (
        @(posedge link_clk) disable iff (rst_l)
        $rose(s.sda_oe) |-> !$past(scl)
    ) else $error("data line driven while clock high");

    chk_ctrl_mismatch_nack: assert property (
        @(posedge link_clk) disable iff (rst_l)
        (s.st == ST_CTRL && scl_fall && s.bitcnt == ACK_BIT && !s.ackph && ce_l
         && !start_evt && !stop_evt && s.shreg[7:1] != s.my_addr
         && s.shreg[7:1] != GENERAL_CALL) |=> released_s
    ) else $error("foreign address not ignored");

    chk_not_ready_quiet: assert property (
        @(posedge link_clk) disable iff (rst_l)
        !s.ready |-> !s.sda_oe && s.st == ST_IDLE
    ) else $error("bus answered before ready");

    chk_start_decodes: assert property (
        @(posedge link_clk) disable iff (rst_l)
        (start_evt && ce_l && s.ready) |=> s.st == ST_CTRL && s.bitcnt == 4'h0 && !s.sda_oe
    ) else $error("start did not restart decoding");

    chk_stop_aborts: assert property (
        @(posedge link_clk) disable iff (rst_l)
        (stop_evt && ce_l) |=> s.st == ST_IDLE && !s.hold && !s.ackph
    ) else $error("stop did not abort transfer");

    chk_byte_eight: assert property (
        @(posedge link_clk) disable iff (rst_l)
        $rose(s.ackph) |-> $past(s.bitcnt) == ACK_BIT
    ) else $error("acknowledge not after eight bits");

    chk_fixed_ptr: assert property (
        @(posedge link_clk) disable iff (rst_l)
        (s.dir == DIR_FIXED && !addr_load) |=> $stable(s.ptr)
    ) else $error("fixed pointer moved");

    chk_ptr_inc_read: assert property (
        @(posedge link_clk) disable iff (rst_l)
        (s.st == ST_RDATA && s.mack && scl_rise && !sda && s.dir == DIR_INC && ce_l
         && !start_evt && !stop_evt) |=> s.ptr == $past(s.ptr) + PTR_ONE
    ) else $error("read pointer did not advance");

    chk_wake_stretch: assert property (
        @(posedge link_clk) disable iff (rst_l)
        (start_evt && lp && ce_l && (s.ready || init)) |=> s.wake_req && s.scl_oe
    ) else $error("wake start did not stretch clock");

    chk_write_pulse: assert property (
        @(posedge clk) disable iff (reset)
        (c.reg_wr && ce) |=> !c.reg_wr
    ) else $error("register write longer than one cycle");
endmodule : i2c_slave_access
`default_nettype wire

// ==== common/i2c_slave_pkg.sv ====
// shared constants and types for the two-wire register access slave
package i2c_slave_pkg;
    localparam logic [3:0] ACK_BIT      = 4'h8;
    localparam int         PTR_W        = 14;
    localparam int         DIR_MSB      = 7;
    localparam int         DIR_LSB      = 6;
    localparam int         PTR_HI_BITS  = 6;
    localparam logic [1:0] DIR_INC      = 2'h0;
    localparam logic [1:0] DIR_RSVD     = 2'h1;
    localparam logic [1:0] DIR_DEC      = 2'h2;
    localparam logic [1:0] DIR_FIXED    = 2'h3;
    localparam logic [6:0] GENERAL_CALL = 7'h00;
    // arbitrary slave addresses picked by the strap level
    localparam logic [6:0] SLAVE_ADDR_STRAP_LO = 7'h2A;
    localparam logic [6:0] SLAVE_ADDR_STRAP_HI = 7'h2B;
    localparam logic [PTR_W-1:0] PTR_ONE       = 14'h0001;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_CTRL    = 3'b001,
        ST_GC2     = 3'b010,
        ST_ADDR_HI = 3'b011,
        ST_ADDR_LO = 3'b100,
        ST_WDATA   = 3'b101,
        ST_RDATA   = 3'b110,
        ST_IGNORE  = 3'b111
    } link_st_t;

    typedef struct packed {
        logic             write;
        logic [PTR_W-1:0] addr;
        logic [7:0]       data;
    } reg_req_t;

    typedef struct packed {
        link_st_t         st;
        logic [3:0]       bitcnt;
        logic             ackph;
        logic             mack;
        logic [7:0]       shreg;
        logic [7:0]       addr_hi;
        logic [PTR_W-1:0] ptr;
        logic [1:0]       dir;
        logic [1:0]       nbytes;
        logic             ready;
        logic             strap_taken;
        logic [6:0]       my_addr;
        logic             sda_oe;
        logic             scl_oe;
        logic             sda_o;
        logic             scl_o;
        logic             waking;
        logic             wake_req;
        logic             hold;
        logic             req_tgl;
        reg_req_t         req;
        logic             prev_scl;
        logic             prev_sda;
    } link_state_t;

    typedef struct packed {
        logic             req_seen;
        logic             ack_tgl;
        logic             rd_pend;
        logic [PTR_W-1:0] reg_addr;
        logic [7:0]       reg_wdata;
        logic             reg_wr;
        logic             reg_rd;
        logic [7:0]       rdata;
    } core_state_t;
endpackage : i2c_slave_pkg

// ==== rtl/level_sync.sv ====
// two-stage synchroniser for a bundle of levels
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
    } sync_state_t;

    sync_state_t s;
    sync_state_t n;

    // no reset: a reset here would only delay the first valid sample
    always_comb begin
        n.meta = d;
        n.q    = s.meta;
    end

    always_ff @(posedge clk) begin
        s <= n;
    end

    assign q = s.q;
endmodule : level_sync
`default_nettype wire

// ==== tb/i2c_host_model.sv ====
// bit-level two-wire bus master standing at the slave's far side
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
    input  wire logic scl_wire,
    input  wire logic sda_wire,
    output logic      scl_pull,
    output logic      sda_pull
);
    localparam int HALF = 640;
    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end
    // one clock pulse; waits out any stretching before timing the high phase
    task automatic bit_io(input logic b, output logic r);
        sda_pull = ~b;
        #(HALF);
        scl_pull = 1'b0;
        wait (scl_wire === 1'b1);
        #(HALF / 2);
        r = sda_wire;
        #(HALF / 2);
        scl_pull = 1'b1;
        #(HALF / 4);
    endtask : bit_io
    // s=1 start or repeated start, s=0 stop
    task automatic cond(input logic s);
        sda_pull = ~s;
        #(HALF);
        scl_pull = 1'b0;
        wait (scl_wire === 1'b1);
        #(HALF);
        sda_pull = s;
        #(HALF);
        scl_pull = s;
        #(HALF / 4);
    endtask : cond
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask : wr_byte
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(last, r);
    endtask : rd_byte
endmodule : i2c_host_model
`default_nettype wire

// ==== tb/i2c_slave_register_access_tb_top.sv ====
// self-checking bench for the two-wire register access slave
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_register_access_tb_top;
    import i2c_slave_pkg::*;
    logic             clk, link_clk, reset, strap, init_done, low_power, clocks_locked;
    logic             scl_oe, sda_oe, wake_req, reg_wr, m_scl, m_sda, a;
    logic             ce, scl_o, sda_o, reg_rd;
    logic [PTR_W-1:0] reg_addr, ptr;
    logic [7:0]       reg_wdata, d;
    logic [7:0]       mem [2**PTR_W];
    logic [1:0]       dir;
    logic [5:0]       dirs = {DIR_DEC, DIR_FIXED, DIR_INC};
    logic [31:0]      seed = 32'h00014129;
    logic [21:0]      wq [$];
    int               n_errors, n_tests;
    wire              scl_w = ~(m_scl | scl_oe);
    wire              sda_w = ~(m_sda | sda_oe);
    wire logic [6:0]  me = strap ? SLAVE_ADDR_STRAP_HI : SLAVE_ADDR_STRAP_LO;

    i2c_slave_access dut (
        .clk(clk), .reset(reset), .ce(ce), .link_clk(link_clk),
        .serial_clock_pin_in(scl_w), .serial_clock_pin_out(scl_o), .serial_clock_pin_oe(scl_oe),
        .serial_data_pin_in(sda_w), .serial_data_pin_out(sda_o), .serial_data_pin_oe(sda_oe),
        .addr_select_strap(strap), .init_done(init_done), .low_power(low_power),
        .clocks_locked(clocks_locked), .wake_req(wake_req), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(mem[reg_addr])
    );
    i2c_host_model m (.scl_wire(scl_w), .sda_wire(sda_w), .scl_pull(m_scl), .sda_pull(m_sda));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #16 link_clk = ~link_clk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // rare one-cycle freezes exercise the clock enable on both sides
    always @(posedge clk) begin
        ce <= reset || ((rnd() & 32'h7) != 32'h0);
    end
    function automatic logic [PTR_W-1:0] st(input logic [PTR_W-1:0] p);
        return dir == DIR_INC ? p + PTR_ONE : dir == DIR_DEC ? p - PTR_ONE : p;
    endfunction : st
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test;
        if (n_errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test
    task automatic wb(input logic [7:0] v, input logic exp);
        m.wr_byte(v, a);
        check(a, exp);
    endtask : wb
    task automatic cmd(input logic [7:0] c, input logic exp);
        m.cond(1'b1);
        wb(c, exp);
    endtask : cmd
    // master always sends both address bytes, step field in the top two bits
    task automatic addr(input logic gc, input logic [1:0] dr, input logic [PTR_W-1:0] p);
        if (gc) begin
            cmd(8'h00, 1'b1);
            wb(8'h01, 1'b1);
        end else begin
            cmd({me, 1'b0}, 1'b1);
        end
        wb({dr, p[13:8]}, 1'b1);
        wb(p[7:0], 1'b1);
        dir = dr;
        ptr = p;
    endtask : addr
    task automatic wdata(input int n);
        logic [PTR_W-1:0] p0;
        p0 = ptr;
        for (int k = 0; k < n; k++) begin
            d = 8'(rnd());
            wq.push_back({ptr, d});
            wb(d, 1'b1);
            ptr = st(ptr);
        end
        if (n == 1) ptr = p0;
        m.cond(1'b0);
    endtask : wdata
    task automatic rdata(input int n);
        logic [PTR_W-1:0] p0;
        p0 = ptr;
        cmd({me, 1'b1}, 1'b1);
        for (int k = 1; k <= n; k++) begin
            m.rd_byte(k == n, d);
            check(d, mem[ptr]);
            ptr = st(ptr);
        end
        if (n == 1) ptr = p0;
        m.cond(1'b0);
    endtask : rdata
    // a pulse frozen by the clock enable is one write, taken at its enabled edge
    always @(posedge clk) begin
        if (reg_rd === 1'b1) check(reg_wr, 1'b0);
        if (reg_wr === 1'b1 && ce === 1'b1) begin
            mem[reg_addr] <= reg_wdata;
            if (wq.size() == 0) check(32'h1, 32'h0);
            else check({reg_addr, reg_wdata}, wq.pop_front());
        end
    end
    initial begin
        #3000000;
        n_errors++;
        end_of_test();
    end
    initial begin
        reset = 1'b1;
        strap = rnd() > 32'h7FFFFFFF;
        init_done = 1'b0;
        low_power = 1'b0;
        clocks_locked = 1'b1;
        for (int i = 0; i < 2**PTR_W; i++) mem[i] = 8'(i * 7);
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        repeat (20) @(posedge clk);
        cmd({me, 1'b0}, 1'b0);
        wb(8'h00, 1'b0);
        m.cond(1'b0);
        @(posedge clk) init_done <= 1'b1;
        repeat (20) @(posedge clk);
        cmd({me ^ 7'h01, 1'b0}, 1'b0);
        m.cond(1'b0);
        addr(1'b0, DIR_INC, 14'h3FFE);
        wdata(3);
        rdata(2);
        for (int i = 0; i < 3; i++) begin
            addr(1'b0, dirs[5-2*i -: 2], 14'(rnd()));
            wdata(2);
            rdata(3);
        end
        addr(1'b0, DIR_INC, 14'(rnd()));
        m.cond(1'b0);
        rdata(1);
        // repeated start straight after the address bytes
        addr(1'b0, DIR_DEC, 14'(rnd()));
        rdata(1);
        addr(1'b0, DIR_INC, 14'(rnd()));
        for (int i = 0; i < 4; i++) m.bit_io(1'b1, a);
        m.cond(1'b0);
        cmd(8'h00, 1'b1);
        wb(8'h04, 1'b0);
        wb(8'(rnd()), 1'b0);
        m.cond(1'b0);
        addr(1'b1, DIR_DEC, 14'(rnd()));
        wdata(2);
        @(posedge clk) begin
            low_power <= 1'b1;
            clocks_locked <= 1'b0;
        end
        fork
            begin
                addr(1'b0, DIR_FIXED, 14'(rnd()));
                wdata(2);
            end
            begin
                repeat (200) @(posedge clk);
                check(wake_req, 1'b1);
                check(scl_oe, 1'b1);
                clocks_locked <= 1'b1;
                low_power <= 1'b0;
            end
        join
        rdata(2);
        repeat (50) @(posedge clk);
        check(wq.size(), 32'h0);
        check({scl_o, sda_o}, 32'h0);
        end_of_test();
    end
endmodule : i2c_slave_register_access_tb_top
`default_nettype wire
